/* File: dv/awsc_media_model.sv */
`timescale 1ns/1ps
`default_nettype none
module awsc_media_model (
	// clock and bench controls
	input  wire logic       clk,
	input  wire logic       clr,
	input  wire logic [3:0] dly,
	input  wire logic [9:0] fail_at,
	input  wire logic       idnf,
	// media handshake
	input  wire logic       media_commit,
	input  wire logic       media_flush,
	output logic            media_done,
	output logic            media_fail,
	output logic            media_idnf,
	output logic            media_flush_done
);
	// ---
	// commit and flush responder
	// ---
	logic [3:0] w; // wait counter, dly gives prompt or slow answers
	logic [9:0] n; // sectors committed since clr
	always @(posedge clk)
	begin
		media_done <= 1'b0;
		media_flush_done <= 1'b0;
		// qualifiers toggle outside a done pulse, so stale values never pass
		media_fail <= ~media_fail;
		media_idnf <= ~media_idnf;
		if (clr)
		begin
			n <= 10'h000;
			w <= 4'h0;
			media_fail <= 1'b0;
			media_idnf <= 1'b0;
		end
		else if (media_commit && !media_done)
		begin
			w <= w + 4'h1;
			if (w == dly)
			begin
				w <= 4'h0;
				media_done <= 1'b1;
				media_fail <= (n == fail_at) && !idnf;
				media_idnf <= (n == fail_at) && idnf;
				n <= n + 10'h001;
			end
		end
		else if (media_flush && !media_flush_done)
		begin
			w <= w + 4'h1;
			if (w == dly)
			begin
				w <= 4'h0;
				media_flush_done <= 1'b1;
			end
		end
		else
			w <= 4'h0;
	end
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int WPS = 4; // short sectors keep the run brief
	logic        clk;
	logic        sys_rst = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic        media_word_valid;
	logic [15:0] media_word_data;
	logic [47:0] media_lba;
	logic        media_commit;
	logic        media_done;
	logic        media_fail;
	logic        media_idnf;
	logic        media_flush;
	logic        media_flush_done;
	logic [7:0]  multi_blk_size = 8'h00;
	logic        intrq;
	logic        clr = 1'b1;
	logic [3:0]  dly = 4'h0;
	logic [9:0]  fail_at = 10'h3FF;
	logic        idnf = 1'b0;
	logic        irq_q = 1'b0;
	logic [15:0] seq = 16'h0000;
	logic [15:0] mon_seq = 16'h0000;
	int          failures = 0;
	int          check_count = 0;
	int          irq_n = 0;
	int          flush_n = 0;

	awsc_exec #(.WORDS_PER_SECTOR(WPS)) u_dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .media_word_valid, .media_word_data, .media_lba, .media_commit, .media_done,
		.media_fail, .media_idnf, .media_flush, .media_flush_done, .multi_blk_size, .intrq);
	awsc_media_model u_media (.clk, .clr, .dly, .fail_at, .idnf, .media_commit, .media_flush,
		.media_done, .media_fail, .media_idnf, .media_flush_done);

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ---
	// helpers
	// ---
	task automatic close_out;
		$display("checks %0d, failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// data stand from the cycle after the strobe cycle until the next read
	task automatic rdc(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk({40'h0, reg_rdata[7:0] & m}, {40'h0, e & m});
	endtask

	// read back the three address registers, ADDR0 first, as the high byte select picks
	task automatic ad3(input logic [23:0] e);
		rdc(awsc_pkg::REG_ADDR0, e[7:0]);
		rdc(awsc_pkg::REG_ADDR1, e[15:8]);
		rdc(awsc_pkg::REG_ADDR2, e[23:16]);
	endtask

	// writing twice pushes the first byte into the previous slot
	task automatic ld(input logic [3:0] a, input logic [7:0] c, input logic [7:0] p);
		wr(a, {8'h00, p});
		wr(a, {8'h00, c});
	endtask

	task automatic poll(input logic [7:0] m, input logic [7:0] v);
		for (int i = 0; i < 400; i++)
		begin
			@(posedge clk);
			reg_addr <= awsc_pkg::REG_CMD_STAT;
			reg_rd <= 1'b1;
			@(posedge clk);
			reg_rd <= 1'b0;
			#1;
			if ((reg_rdata[7:0] & m) === v)
				return;
		end
		failures++;
		$display("mismatch at %0t: status wait ran out", $time);
		close_out();
	endtask

	// issue a command and move ns sectors of counted words
	task automatic exec(input logic [7:0] cmd, input int ns, input logic [47:0] l0, input logic [7:0] blk);
		multi_blk_size <= blk;
		// restart the media sector count, so fail_at counts from this command
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		irq_n = 0;
		flush_n = 0;
		wr(awsc_pkg::REG_CMD_STAT, {8'h00, cmd});
		for (int s = 0; s < ns; s++)
		begin
			poll(8'h08, 8'h08);
			for (int k = 0; k < WPS; k++)
			begin
				wr(awsc_pkg::REG_DATA, seq);
				seq++;
			end
			#1;
			chk(media_lba, l0 + 48'(s));
		end
		poll(8'h88, 8'h00);
	endtask

	// ---
	// port monitor: words in order, interrupt and flush counts
	// ---
	always @(posedge clk)
	begin
		irq_q <= intrq;
		if (intrq === 1'b1 && irq_q !== 1'b1)
			irq_n++;
		if (media_flush_done === 1'b1 && media_flush === 1'b1)
			flush_n++;
		if (media_word_valid === 1'b1)
		begin
			chk({32'h0, media_word_data}, {32'h0, mon_seq});
			mon_seq++;
		end
	end

	// ---
	// scenarios
	// ---
	task automatic s_reset;
		rdc(awsc_pkg::REG_CMD_STAT, 8'h50);
		rdc(awsc_pkg::REG_FEAT_ERR, 8'h00);
		rdc(4'h9, 8'h00); // unmapped index reads zero
		chk({47'h0, intrq}, 48'h0);
	endtask

	// retry bit set, slow media, address crosses into the head nibble
	task automatic s_lba28;
		dly <= 4'h6;
		wr(awsc_pkg::REG_COUNT, 16'h0003);
		ad3_wr(24'hFF_FFFE);
		wr(awsc_pkg::REG_DRIVE, 16'h00E1);
		exec(8'h31, 3, 48'h0000_01FF_FFFE, 8'h00);
		chk(48'(irq_n), 48'h3);
		rdc(awsc_pkg::REG_COUNT, 8'h00);
		ad3(24'h00_0000);
		rdc(awsc_pkg::REG_DRIVE, 8'h02, 8'h0F);
		rdc(awsc_pkg::REG_CMD_STAT, 8'h50);
	endtask

	task automatic ad3_wr(input logic [23:0] v);
		wr(awsc_pkg::REG_ADDR0, {8'h00, v[7:0]});
		wr(awsc_pkg::REG_ADDR1, {8'h00, v[15:8]});
		wr(awsc_pkg::REG_ADDR2, {8'h00, v[23:16]});
	endtask

	// a zero count asks for a full 256 sectors
	task automatic s_zero;
		dly <= 4'h0;
		wr(awsc_pkg::REG_COUNT, 16'h0000);
		ad3_wr(24'hBC_DEF0);
		wr(awsc_pkg::REG_DRIVE, 16'h00EA);
		exec(8'h30, 256, 48'h0000_0ABC_DEF0, 8'h00);
		ad3(24'hBC_DFEF);
		rdc(awsc_pkg::REG_COUNT, 8'h00);
	endtask

	// uncorrectable failure on the third of five sectors
	task automatic s_fail;
		dly <= 4'h2;
		fail_at <= 10'h002;
		wr(awsc_pkg::REG_COUNT, 16'h0005);
		ad3_wr(24'h00_0100);
		wr(awsc_pkg::REG_DRIVE, 16'h00E0);
		exec(8'h30, 3, 48'h0000_0000_0100, 8'h00);
		rdc(awsc_pkg::REG_FEAT_ERR, 8'h04);
		rdc(awsc_pkg::REG_CMD_STAT, 8'h51);
		rdc(awsc_pkg::REG_COUNT, 8'h03);
		ad3(24'h00_0102);
		fail_at <= 10'h3FF;
	endtask

	// two sectors in CHS form, so the sector field steps once
	task automatic s_chs;
		wr(awsc_pkg::REG_COUNT, 16'h0002);
		ad3_wr(24'h12_3405);
		wr(awsc_pkg::REG_DRIVE, 16'h00A3);
		exec(8'h30, 2, 48'h0000_0312_3405, 8'h00);
		ad3(24'h12_3406);
		rdc(awsc_pkg::REG_DRIVE, 8'h03, 8'h0F);
	endtask

	// two-byte count of 258 sectors in blocks of two
	task automatic s_fua;
		ld(awsc_pkg::REG_COUNT, 8'h02, 8'h01);
		ld(awsc_pkg::REG_ADDR0, 8'hF6, 8'hC3);
		ld(awsc_pkg::REG_ADDR1, 8'hE5, 8'hB2);
		ld(awsc_pkg::REG_ADDR2, 8'hD4, 8'hA1);
		wr(awsc_pkg::REG_DRIVE, 16'h0040);
		exec(8'hCE, 258, 48'hA1B2_C3D4_E5F6, 8'h02);
		chk(48'(irq_n), 48'd129);
		chk(48'(flush_n), 48'h1);
		rdc(awsc_pkg::REG_CMD_STAT, 8'h50);
		ad3(24'hD4_E6F7);
		wr(awsc_pkg::REG_DEVCTL, 16'h0080);
		ad3(24'hA1_B2C3);
		wr(awsc_pkg::REG_DEVCTL, 16'h0000);
	endtask

	// id-not-found on the second sector, across a 40-bit carry
	task automatic s_fua_err;
		dly <= 4'h1;
		fail_at <= 10'h001;
		idnf <= 1'b1;
		ld(awsc_pkg::REG_COUNT, 8'h03, 8'h00);
		ld(awsc_pkg::REG_ADDR0, 8'hFF, 8'hFF);
		ld(awsc_pkg::REG_ADDR1, 8'hFF, 8'hFF);
		ld(awsc_pkg::REG_ADDR2, 8'hFF, 8'h00);
		exec(8'hCE, 2, 48'h00FF_FFFF_FFFF, 8'h00);
		rdc(awsc_pkg::REG_FEAT_ERR, 8'h10);
		rdc(awsc_pkg::REG_CMD_STAT, 8'h51);
		ad3(24'h00_0000);
		wr(awsc_pkg::REG_DEVCTL, 16'h0080);
		ad3(24'h01_0000);
		wr(awsc_pkg::REG_DEVCTL, 16'h0000);
		fail_at <= 10'h3FF;
		idnf <= 1'b0;
	endtask

	task automatic s_badcmd;
		wr(awsc_pkg::REG_CMD_STAT, 16'h00C5);
		poll(8'h88, 8'h00);
		rdc(awsc_pkg::REG_FEAT_ERR, 8'h04);
		rdc(awsc_pkg::REG_CMD_STAT, 8'h51);
	endtask

	// ---
	// main sequence
	// ---
	initial
	begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		clr <= 1'b0;
		s_reset();
		s_lba28();
		s_zero();
		s_fail();
		s_chs();
		s_fua();
		s_fua_err();
		s_badcmd();
		close_out();
	end
endmodule
`default_nettype wire

/* File: rtl/awsc_exec.sv */
`timescale 1ns/1ps
`default_nettype none
module awsc_exec #(
	parameter int         WORDS_PER_SECTOR = 256,  // 16-bit words per sector
	parameter logic [7:0] SECT_PER_TRACK   = 8'h3F, // CHS geometry, sectors
	parameter logic [3:0] HEAD_LAST        = 4'hF   // CHS geometry, last head
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// media side
	output logic             media_word_valid,
	output logic      [15:0] media_word_data,
	output logic      [47:0] media_lba,
	output logic             media_commit,
	input  wire logic        media_done,
	input  wire logic        media_fail,
	input  wire logic        media_idnf,
	output logic             media_flush,
	input  wire logic        media_flush_done,
	// configuration and host event
	input  wire logic [7:0]  multi_blk_size,
	output logic             intrq
);
	//----------------------------------------
	// state
	//----------------------------------------
	typedef struct packed {
		logic [7:0]          cnt_cur;   // count, current byte
		logic [7:0]          cnt_prev;  // count, previous byte
		logic [7:0]          a0_cur;    // address byte 0
		logic [7:0]          a0_prev;
		logic [7:0]          a1_cur;    // address byte 1
		logic [7:0]          a1_prev;
		logic [7:0]          a2_cur;    // address byte 2
		logic [7:0]          a2_prev;
		logic [7:0]          drive;     // drive select and upper address
		logic                high_byte_select;       // high_byte_select
		logic                err_idn;
		logic                err_abt;
		logic                st_err;
		logic                bsy;
		logic                drq;
		logic                irq;
		awsc_pkg::awsc_phase_t phase;
		logic                ext;       // 48-bit command running
		logic                lba_mode;  // 28-bit command in LBA form
		logic [47:0]         lba;       // working address
		logic [16:0]         remain;    // sectors not yet written
		logic [15:0]         word_cnt;  // words into this sector
		logic [7:0]          blk_cnt;   // sectors into this block
		logic [15:0]         rdata;
		logic                mw_valid;
		logic [15:0]         mw_data;
	} awsc_state_t;

	localparam awsc_state_t STATE_RESET = '0;
	localparam logic [15:0] WORD_LAST = 16'(WORDS_PER_SECTOR - 1);

	awsc_state_t s;
	awsc_state_t next_s;

	//----------------------------------------
	// helpers
	//----------------------------------------
	// step to the following sector; CHS walks sector, head, cylinder
	function automatic logic [47:0] step_addr(input logic [47:0] a, input logic chs);
		logic [47:0] r;
		r = a + awsc_pkg::LBA_ONE;
		if (chs)
		begin
			r = a;
			if (a[7:0] == SECT_PER_TRACK)
			begin
				r[7:0] = awsc_pkg::BYTE_ONE;
				if (a[27:24] == HEAD_LAST)
				begin
					r[27:24] = 4'h0;
					r[23:8]  = a[23:8] + awsc_pkg::WORD_ONE;
				end
				else
					r[27:24] = a[27:24] + awsc_pkg::NIBBLE_ONE;
			end
			else
				r[7:0] = a[7:0] + awsc_pkg::BYTE_ONE;
		end
		return r;
	endfunction

	// end of command: copy back address and leftover count, post status
	function automatic awsc_state_t finish(input awsc_state_t t);
		awsc_state_t r;
		r = t;
		r.a0_cur   = t.lba[7:0];
		r.a1_cur   = t.lba[15:8];
		r.a2_cur   = t.lba[23:16];
		r.cnt_cur  = t.remain[7:0];
		r.cnt_prev = t.remain[15:8];
		if (t.ext)
		begin
			r.a0_prev = t.lba[31:24];
			r.a1_prev = t.lba[39:32];
			r.a2_prev = t.lba[47:40];
		end
		else
			r.drive[3:0] = t.lba[27:24];
		r.bsy   = 1'b0;
		r.drq   = 1'b0;
		r.irq   = 1'b1;
		r.phase = awsc_pkg::AWSC_IDLE;
		return r;
	endfunction

	//----------------------------------------
	// next state
	//----------------------------------------
	always_comb
	begin
		next_s = s;
		next_s.mw_valid = 1'b0;
		// register reads answer one cycle later
		if (reg_rd)
		begin
			unique case (reg_addr)
				awsc_pkg::REG_DATA:     next_s.rdata = 16'h0000;
				awsc_pkg::REG_FEAT_ERR: next_s.rdata = {11'h000, s.err_idn, 1'b0, s.err_abt, 2'b00};
				awsc_pkg::REG_COUNT:    next_s.rdata = {8'h00, s.high_byte_select ? s.cnt_prev : s.cnt_cur};
				awsc_pkg::REG_ADDR0:    next_s.rdata = {8'h00, s.high_byte_select ? s.a0_prev : s.a0_cur};
				awsc_pkg::REG_ADDR1:    next_s.rdata = {8'h00, s.high_byte_select ? s.a1_prev : s.a1_cur};
				awsc_pkg::REG_ADDR2:    next_s.rdata = {8'h00, s.high_byte_select ? s.a2_prev : s.a2_cur};
				awsc_pkg::REG_DRIVE:    next_s.rdata = {8'h00, s.drive};
				awsc_pkg::REG_CMD_STAT:
				begin
					// reading status acknowledges the interrupt
					next_s.rdata = {8'h00, awsc_pkg::STATUS_FIXED | {s.bsy, 3'b000, s.drq, 2'b00, s.st_err}};
					next_s.irq   = 1'b0;
				end
				default:                next_s.rdata = 16'h0000; // unmapped reads zero
			endcase
		end
		// task-file writes are refused while busy or moving data
		if (reg_wr && s.phase == awsc_pkg::AWSC_IDLE)
		begin
			unique case (reg_addr)
				awsc_pkg::REG_COUNT:
				begin
					next_s.cnt_prev = s.cnt_cur;
					next_s.cnt_cur  = reg_wdata[7:0];
					next_s.high_byte_select      = 1'b0;
				end
				awsc_pkg::REG_ADDR0:
				begin
					next_s.a0_prev = s.a0_cur;
					next_s.a0_cur  = reg_wdata[7:0];
					next_s.high_byte_select     = 1'b0;
				end
				awsc_pkg::REG_ADDR1:
				begin
					next_s.a1_prev = s.a1_cur;
					next_s.a1_cur  = reg_wdata[7:0];
					next_s.high_byte_select     = 1'b0;
				end
				awsc_pkg::REG_ADDR2:
				begin
					next_s.a2_prev = s.a2_cur;
					next_s.a2_cur  = reg_wdata[7:0];
					next_s.high_byte_select     = 1'b0;
				end
				awsc_pkg::REG_DRIVE:  next_s.drive = reg_wdata[7:0];
				awsc_pkg::REG_DEVCTL: next_s.high_byte_select   = reg_wdata[awsc_pkg::DEVCTL_HOB_BIT];
				awsc_pkg::REG_CMD_STAT:
				begin
					next_s.err_idn  = 1'b0;
					next_s.err_abt  = 1'b0;
					next_s.st_err   = 1'b0;
					next_s.word_cnt = 16'h0000;
					next_s.blk_cnt  = 8'h00;
					if (reg_wdata[7:0] == awsc_pkg::CMD_WR_MULTI_FUA)
					begin
						next_s.ext    = 1'b1;
						next_s.remain = ({s.cnt_prev, s.cnt_cur} == 16'h0000) ?
							awsc_pkg::COUNT48_ZERO : {1'b0, s.cnt_prev, s.cnt_cur};
						next_s.lba    = {s.a2_prev, s.a1_prev, s.a0_prev, s.a2_cur, s.a1_cur, s.a0_cur};
						next_s.phase  = awsc_pkg::AWSC_XFER;
						next_s.drq    = 1'b1;
					end
					else if ((reg_wdata[7:0] & awsc_pkg::CMD_RETRY_MASK) == awsc_pkg::CMD_WR_SECT)
					begin
						next_s.ext      = 1'b0;
						next_s.lba_mode = s.drive[awsc_pkg::DRIVE_LBA_BIT];
						next_s.remain   = (s.cnt_cur == awsc_pkg::BYTE_ZERO) ?
							awsc_pkg::COUNT28_ZERO : {9'h000, s.cnt_cur};
						next_s.lba      = {awsc_pkg::LBA28_PAD, s.drive[3:0], s.a2_cur, s.a1_cur, s.a0_cur};
						next_s.phase    = awsc_pkg::AWSC_XFER;
						next_s.drq      = 1'b1;
					end
					else
					begin
						// any other code is aborted at once
						next_s.err_abt = 1'b1;
						next_s.st_err  = 1'b1;
						next_s.irq     = 1'b1;
					end
				end
				default: ; // data and feature writes have no effect here
			endcase
		end
		unique case (s.phase)
			awsc_pkg::AWSC_IDLE: ;
			awsc_pkg::AWSC_XFER:
			begin
				// each host word goes straight to the media in order
				if (reg_wr && reg_addr == awsc_pkg::REG_DATA)
				begin
					next_s.mw_valid = 1'b1;
					next_s.mw_data  = reg_wdata;
					next_s.word_cnt = s.word_cnt + awsc_pkg::WORD_ONE;
					if (s.word_cnt == WORD_LAST)
					begin
						next_s.word_cnt = 16'h0000;
						next_s.drq      = 1'b0;
						next_s.bsy      = 1'b1;
						next_s.phase    = awsc_pkg::AWSC_COMMIT;
					end
				end
			end
			awsc_pkg::AWSC_COMMIT:
			begin
				if (media_done)
				begin
					if (media_fail || media_idnf)
					begin
						// stop at the failing sector; its address stays
						next_s.err_idn = media_idnf;
						next_s.err_abt = media_fail;
						next_s.st_err  = 1'b1;
						next_s = finish(next_s);
					end
					else if (s.remain == awsc_pkg::COUNT_ONE)
					begin
						next_s.remain = 17'h0_0000;
						if (s.ext)
							next_s.phase = awsc_pkg::AWSC_FLUSH;
						else
							next_s = finish(next_s);
					end
					else
					begin
						next_s.remain  = s.remain - awsc_pkg::COUNT_ONE;
						next_s.lba     = step_addr(s.lba, !s.ext && !s.lba_mode);
						next_s.blk_cnt = s.blk_cnt + awsc_pkg::BYTE_ONE;
						next_s.bsy     = 1'b0;
						next_s.drq     = 1'b1;
						next_s.phase   = awsc_pkg::AWSC_XFER;
						// a block size of zero or one acts per sector
						if (!s.ext || next_s.blk_cnt >= multi_blk_size)
						begin
							next_s.blk_cnt = 8'h00;
							next_s.irq     = 1'b1;
						end
					end
				end
			end
			awsc_pkg::AWSC_FLUSH:
			begin
				// ending status waits until cached data is on the media
				if (media_flush_done)
					next_s = finish(next_s);
			end
		endcase
	end

	//----------------------------------------
	// registers
	//----------------------------------------
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			s <= STATE_RESET;
		else
			s <= next_s;
	end

	// outputs
	assign reg_rdata        = s.rdata;
	assign media_word_valid = s.mw_valid;
	assign media_word_data  = s.mw_data;
	assign media_lba        = s.lba;
	assign media_commit     = (s.phase == awsc_pkg::AWSC_COMMIT);
	assign media_flush      = (s.phase == awsc_pkg::AWSC_FLUSH);
	assign intrq            = s.irq;

	//----------------------------------------
	// checks
	//----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	wire cmd_wr  = reg_wr && reg_addr == awsc_pkg::REG_CMD_STAT && s.phase == awsc_pkg::AWSC_IDLE;
	wire good_ok = media_done && !media_fail && !media_idnf && media_commit;

	property p_fua_start;
		cmd_wr && reg_wdata[7:0] == awsc_pkg::CMD_WR_MULTI_FUA |=> s.phase == awsc_pkg::AWSC_XFER && s.ext && s.drq;
	endproperty
	a_fua_start: assert property (p_fua_start) else $error("fua write did not start");

	property p_flush_first;
		good_ok && s.ext && s.remain == awsc_pkg::COUNT_ONE |=> (media_flush && s.bsy && !s.irq)[*2];
	endproperty
	a_flush_first: assert property (p_flush_first) else $error("status before media flush");

	sequence q_mid_sector;
		good_ok && s.ext && s.remain != awsc_pkg::COUNT_ONE && !s.irq;
	endsequence
	property p_block_irq;
		q_mid_sector ##0 (s.blk_cnt + awsc_pkg::BYTE_ONE < multi_blk_size) |=> !s.irq && s.drq;
	endproperty
	a_block_irq: assert property (p_block_irq) else $error("interrupt inside a block");

	property p_word_pass;
		reg_wr && reg_addr == awsc_pkg::REG_DATA && s.phase == awsc_pkg::AWSC_XFER
			|=> media_word_valid && media_word_data == $past(reg_wdata);
	endproperty
	a_word_pass: assert property (p_word_pass) else $error("data word not passed");

	property p_count48;
		cmd_wr && reg_wdata[7:0] == awsc_pkg::CMD_WR_MULTI_FUA |=> s.remain[15:0] == $past({s.cnt_prev, s.cnt_cur})
			&& s.remain[16] == ($past({s.cnt_prev, s.cnt_cur}) == 16'h0000);
	endproperty
	a_count48: assert property (p_count48) else $error("48-bit count wrong");

	property p_lba48;
		cmd_wr && reg_wdata[7:0] == awsc_pkg::CMD_WR_MULTI_FUA
			|=> media_lba[47:40] == $past(s.a2_prev) && media_lba[7:0] == $past(s.a0_cur);
	endproperty
	a_lba48: assert property (p_lba48) else $error("48-bit address wrong");

	property p_retry_ignored;
		cmd_wr && (reg_wdata[7:0] & awsc_pkg::CMD_RETRY_MASK) == awsc_pkg::CMD_WR_SECT
			|=> s.phase == awsc_pkg::AWSC_XFER && !s.ext && !s.err_abt;
	endproperty
	a_retry_ignored: assert property (p_retry_ignored) else $error("sector write not started");

	property p_count28;
		cmd_wr && (reg_wdata[7:0] & awsc_pkg::CMD_RETRY_MASK) == awsc_pkg::CMD_WR_SECT
			|=> s.remain == ($past(s.cnt_cur) == 8'h00 ? awsc_pkg::COUNT28_ZERO : {9'h000, $past(s.cnt_cur)});
	endproperty
	a_count28: assert property (p_count28) else $error("28-bit count wrong");

	property p_stop_on_error;
		media_commit && media_done && (media_fail || media_idnf)
			|=> s.phase == awsc_pkg::AWSC_IDLE && s.st_err && !s.drq && intrq;
	endproperty
	a_stop_on_error: assert property (p_stop_on_error) else $error("write continued after error");

	property p_err_bits;
		reg_rd && reg_addr == awsc_pkg::REG_FEAT_ERR |=> (reg_rdata[7:0] & ~awsc_pkg::ERR_LEGAL_MASK) == 8'h00;
	endproperty
	a_err_bits: assert property (p_err_bits) else $error("illegal error bit set");

	property p_hob_read;
		reg_rd && reg_addr == awsc_pkg::REG_ADDR0 && s.high_byte_select |=> reg_rdata[7:0] == $past(s.a0_prev);
	endproperty
	a_hob_read: assert property (p_hob_read) else $error("high byte read wrong");
endmodule
`default_nettype wire

/* File: rtl/awsc_pkg.sv */
// Summary of operation
// - code CEh starts 48-bit multiple forced-commit write
// - forced-commit write flushes media before error-free ending status
// - multiple write interrupts once per block of sectors
// - sector data moves as ordered 16-bit words
// - 48-bit count from two bytes, zero means 65536
// - 48-bit start address assembled from six address bytes
// - 48-bit error leaves first failing address readable
// - codes 30h and 31h both start sector write
// - 28-bit count of zero means 256 sectors
// - address-mode bit picks CHS or 28-bit LBA
// - uncorrectable error stops write at failing sector
// - count register ends holding sectors not written
// - address registers end holding last transferred sector
// - error bits fixed, only IDN and ABT may set
// - status BSY down to ERR, completion values fixed
package awsc_pkg;
	// task-file register indices on the plain register port
	localparam logic [3:0]  REG_DATA      = 4'h0;
	localparam logic [3:0]  REG_FEAT_ERR  = 4'h1;
	localparam logic [3:0]  REG_COUNT     = 4'h2;
	localparam logic [3:0]  REG_ADDR0     = 4'h3;
	localparam logic [3:0]  REG_ADDR1     = 4'h4;
	localparam logic [3:0]  REG_ADDR2     = 4'h5;
	localparam logic [3:0]  REG_DRIVE     = 4'h6;
	localparam logic [3:0]  REG_CMD_STAT  = 4'h7;
	localparam logic [3:0]  REG_DEVCTL    = 4'h8;
	// command codes
	localparam logic [7:0]  CMD_WR_MULTI_FUA = 8'hCE;
	localparam logic [7:0]  CMD_WR_SECT      = 8'h30;
	localparam logic [7:0]  CMD_RETRY_MASK   = 8'hFE;
	// field positions
	localparam int          DEVCTL_HOB_BIT = 7;
	localparam int          DRIVE_LBA_BIT  = 6;
	localparam int          ERR_IDN_BIT    = 4;
	localparam int          ERR_ABT_BIT    = 2;
	localparam logic [7:0]  ERR_LEGAL_MASK = 8'h14;
	localparam int          ST_BSY_BIT     = 7;
	localparam int          ST_DRQ_BIT     = 3;
	localparam int          ST_ERR_BIT     = 0;
	// fixed status bits: RDY and DSC set, DF COR IDX clear
	localparam logic [7:0]  STATUS_FIXED   = 8'h50;
	// sector counts for a zero count field
	localparam logic [16:0] COUNT48_ZERO   = 17'h1_0000;
	localparam logic [16:0] COUNT28_ZERO   = 17'h0_0100;
	localparam logic [16:0] COUNT_ONE      = 17'h0_0001;
	localparam logic [7:0]  BYTE_ZERO      = 8'h00;
	localparam logic [7:0]  BYTE_ONE       = 8'h01;
	localparam logic [3:0]  NIBBLE_ONE     = 4'h1;
	localparam logic [15:0] WORD_ONE       = 16'h0001;
	localparam logic [47:0] LBA_ONE        = 48'h0000_0000_0001;
	localparam logic [19:0] LBA28_PAD      = 20'h0_0000;
	// execution phases
	typedef enum logic [1:0] {
		AWSC_IDLE,
		AWSC_XFER,
		AWSC_COMMIT,
		AWSC_FLUSH
	} awsc_phase_t;
endpackage
